// ---- pkg/cfgsq_pkg.sv ----
/*
 Constants and carrier types for the configuration sequence controller.
 Assumes a 125 MHz system clock and an asynchronous active-low reset.
*/
package cfgsq_pkg;

	// ==========================================
	// Timing.
	localparam int CLK_PERIOD_NS = 8;
	localparam int POR_DELAY_NS = 1000;
	localparam int POR_DELAY_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int INIT_CYCLES = 64;
	localparam int IMAGE_WORDS = 256;
	localparam int CNT_W = 16;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;
	localparam int SUPPLY_N = 3;

	// ==========================================
	// Reset values.
	localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RST = 16'h0000;

	// ==========================================
	// Life-cycle stages.
	typedef enum logic [2:0] {
		ST_POWERUP = 3'b000,
		ST_POR_WAIT = 3'b001,
		ST_CONFIG = 3'b010,
		ST_ERROR = 3'b011,
		ST_WAIT_DONE = 3'b100,
		ST_INIT = 3'b101,
		ST_USER = 3'b110
	} cfgsq_state_t;

	// Flash read request and memory write carriers.
	typedef struct packed {
		logic req;
		logic [ADDR_W-1:0] addr;
	} cfgsq_flash_req_t;

	typedef struct packed {
		logic we;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} cfgsq_mem_wr_t;

	// Whole module state.
	typedef struct packed {
		cfgsq_state_t st;
		logic [CNT_W-1:0] cnt;
		logic [ADDR_W-1:0] rd_addr;
		logic rd_pend;
		cfgsq_mem_wr_t wr;
		logic status_low;
		logic done_low;
	} cfgsq_regs_t;

endpackage

// ---- hdl/cfgsq_controller.sv ----
/*
 Configuration sequence controller: power-up, image copy, initialization, user mode.
 Assumes flash returns data one or more cycles after a read request, and that
 an outside resolver forms open-drain wire levels from the output enables.
*/
`timescale 1ns/1ps
module cfgsq_controller #(
	parameter int IMAGE_WORDS = cfgsq_pkg::IMAGE_WORDS,
	parameter int INIT_CYCLES = cfgsq_pkg::INIT_CYCLES
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Supply monitors and options.
	input wire logic [cfgsq_pkg::SUPPLY_N-1:0] supply_good,
	input wire logic auto_restart,
	input wire logic io_config_bits,
	input wire logic keep_config_pins,
	// Configuration pins.
	input wire logic reconfig_request_n,
	input wire logic config_status_n_in,
	output logic config_status_n_out,
	output logic config_status_n_oe_n,
	input wire logic config_complete_in,
	output logic config_complete_out,
	output logic config_complete_oe_n,
	input wire logic image_select,
	input wire logic scan_port_enable,
	input wire logic global_clear_n,
	input wire logic global_output_enable,
	input wire logic integrity_fault,
	output logic integrity_fault_out,
	output logic integrity_fault_oe_n,
	// Internal flash read port.
	output cfgsq_pkg::cfgsq_flash_req_t flash_rd,
	input wire logic flash_valid,
	input wire logic flash_error,
	input wire logic [cfgsq_pkg::DATA_W-1:0] flash_data,
	output logic flash_bank,
	// Configuration memory write port.
	output cfgsq_pkg::cfgsq_mem_wr_t mem_wr,
	// User I/O control and status.
	output logic io_weak_pullup,
	output logic io_tristate,
	output logic user_mode,
	output logic user_clear_n,
	output logic user_oe,
	output logic pins_user_io,
	output logic scan_pins_user_io,
	output cfgsq_pkg::cfgsq_state_t stage
);

	cfgsq_pkg::cfgsq_regs_t r;
	cfgsq_pkg::cfgsq_regs_t next_r;
	logic supplies_ok;
	logic last_word;

	// ==========================================
	// Next-state logic.
	localparam int ADDR_W_L = cfgsq_pkg::ADDR_W;
	typedef logic [ADDR_W_L-1:0] cfgsq_addr_t;

	assign supplies_ok = &supply_good;
	assign last_word = (r.rd_addr == cfgsq_addr_t'(IMAGE_WORDS - 1));

	always_comb begin
		next_r = r;
		next_r.wr.we = 1'b0;
		case (r.st)
			cfgsq_pkg::ST_POWERUP: begin
				next_r.status_low = 1'b1;
				next_r.done_low = 1'b1;
				next_r.cnt = cfgsq_pkg::CNT_RST;
				if (supplies_ok) begin
					next_r.st = cfgsq_pkg::ST_POR_WAIT;
				end
			end
			cfgsq_pkg::ST_POR_WAIT: begin
				if (!supplies_ok) begin
					next_r.st = cfgsq_pkg::ST_POWERUP;
				end else if (r.cnt == cfgsq_pkg::CNT_W'(cfgsq_pkg::POR_DELAY_CYC - 1)) begin
					next_r.st = cfgsq_pkg::ST_CONFIG;
					next_r.cnt = cfgsq_pkg::CNT_RST;
					next_r.rd_addr = cfgsq_pkg::ADDR_RST;
					next_r.rd_pend = 1'b0;
					next_r.status_low = 1'b0;
				end else begin
					next_r.cnt = r.cnt + 16'h0001;
				end
			end
			cfgsq_pkg::ST_CONFIG: begin
				if (flash_error) begin
					next_r.st = cfgsq_pkg::ST_ERROR;
					next_r.status_low = 1'b1;
					next_r.rd_pend = 1'b0;
				end else if (!r.rd_pend) begin
					next_r.rd_pend = 1'b1;
				end else if (flash_valid) begin
					next_r.rd_pend = 1'b0;
					next_r.wr.we = 1'b1;
					next_r.wr.addr = r.rd_addr;
					next_r.wr.data = flash_data;
					if (last_word) begin
						next_r.st = cfgsq_pkg::ST_WAIT_DONE;
						next_r.done_low = 1'b0;
					end else begin
						next_r.rd_addr = r.rd_addr + 16'h0001;
					end
				end
			end
			cfgsq_pkg::ST_ERROR: begin
				if (auto_restart) begin
					next_r.st = cfgsq_pkg::ST_POR_WAIT;
					next_r.cnt = cfgsq_pkg::CNT_RST;
				end
				// without auto_restart, error held on status until host request
			end
			cfgsq_pkg::ST_WAIT_DONE: begin
				if (config_complete_in) begin
					next_r.st = cfgsq_pkg::ST_INIT;
					next_r.cnt = cfgsq_pkg::CNT_RST;
				end
			end
			cfgsq_pkg::ST_INIT: begin
				if (r.cnt == cfgsq_pkg::CNT_W'(INIT_CYCLES - 1)) begin
					next_r.st = cfgsq_pkg::ST_USER;
				end else begin
					next_r.cnt = r.cnt + 16'h0001;
				end
			end
			cfgsq_pkg::ST_USER: begin
				next_r.st = cfgsq_pkg::ST_USER;
			end
			default: begin
				next_r.st = cfgsq_pkg::ST_POWERUP;
			end
		endcase
		if (!reconfig_request_n) begin
			next_r.st = cfgsq_pkg::ST_POR_WAIT;
			next_r.cnt = cfgsq_pkg::CNT_RST;
			next_r.rd_pend = 1'b0;
			next_r.status_low = 1'b1;
			next_r.done_low = 1'b1;
		end
		if (!supplies_ok) begin
			next_r.st = cfgsq_pkg::ST_POWERUP;
			next_r.status_low = 1'b1;
			next_r.done_low = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			r <= '{st: cfgsq_pkg::ST_POWERUP, cnt: cfgsq_pkg::CNT_RST,
				rd_addr: cfgsq_pkg::ADDR_RST, rd_pend: 1'b0,
				wr: '0, status_low: 1'b1, done_low: 1'b1};
		end else begin
			r <= next_r;
		end
	end

	// ==========================================
	// Outputs.
	// open-drain lines, enable low drives
	assign config_status_n_out = 1'b0;
	assign config_status_n_oe_n = !(r.status_low || !reconfig_request_n);
	assign config_complete_out = 1'b0;
	assign config_complete_oe_n = !(r.done_low || !reconfig_request_n);
	assign integrity_fault_out = 1'b0;
	assign integrity_fault_oe_n = !(integrity_fault && user_mode);
	assign flash_bank = image_select;
	assign flash_rd.req = (r.st == cfgsq_pkg::ST_CONFIG) && r.rd_pend && !flash_valid;
	assign flash_rd.addr = r.rd_addr;
	assign mem_wr = r.wr;
	assign stage = r.st;
	assign user_mode = (r.st == cfgsq_pkg::ST_USER);
	assign io_weak_pullup = !user_mode && io_config_bits;
	assign io_tristate = !user_mode && !io_config_bits;
	assign user_clear_n = !user_mode || global_clear_n;
	assign user_oe = user_mode && global_output_enable;
	assign pins_user_io = user_mode && !keep_config_pins;
	assign scan_pins_user_io = user_mode && !scan_port_enable;

	// ==========================================
	// Checks.
	property p_req_lines_low;
		@(posedge clk) disable iff (!nrst)
		!reconfig_request_n |-> !config_status_n_oe_n && !config_complete_oe_n;
	endproperty
	a_req_lines_low: assert property (p_req_lines_low) else $error("lines not low");

	property p_io_safe;
		@(posedge clk) disable iff (!nrst)
		!user_mode |-> (io_weak_pullup ^ io_tristate);
	endproperty
	a_io_safe: assert property (p_io_safe) else $error("io not safe");

	property p_por_delay;
		@(posedge clk) disable iff (!nrst)
		(r.st == cfgsq_pkg::ST_CONFIG) && $past(r.st) != cfgsq_pkg::ST_CONFIG
		|-> $past(r.st) == cfgsq_pkg::ST_POR_WAIT;
	endproperty
	a_por_delay: assert property (p_por_delay) else $error("config without delay");

	property p_supply;
		@(posedge clk) disable iff (!nrst)
		!supplies_ok |=> r.st == cfgsq_pkg::ST_POWERUP;
	endproperty
	a_supply: assert property (p_supply) else $error("left powerup early");

	property p_auto;
		@(posedge clk) disable iff (!nrst)
		r.st == cfgsq_pkg::ST_ERROR && auto_restart && supplies_ok
		|=> r.st == cfgsq_pkg::ST_POR_WAIT;
	endproperty
	a_auto: assert property (p_auto) else $error("no auto restart");

	property p_err_hold;
		@(posedge clk) disable iff (!nrst)
		r.st == cfgsq_pkg::ST_ERROR |-> !config_status_n_oe_n;
	endproperty
	a_err_hold: assert property (p_err_hold) else $error("error not flagged");

	sequence s_wait_high;
		r.st == cfgsq_pkg::ST_WAIT_DONE && config_complete_in && reconfig_request_n && supplies_ok;
	endsequence
	property p_init_start;
		@(posedge clk) disable iff (!nrst)
		s_wait_high |=> r.st == cfgsq_pkg::ST_INIT;
	endproperty
	a_init_start: assert property (p_init_start) else $error("init not started");

	property p_done_low;
		@(posedge clk) disable iff (!nrst)
		r.st == cfgsq_pkg::ST_CONFIG |-> !config_complete_oe_n;
	endproperty
	a_done_low: assert property (p_done_low) else $error("done released early");

	property p_abort;
		@(posedge clk) disable iff (!nrst)
		!reconfig_request_n && supplies_ok |=> r.st == cfgsq_pkg::ST_POR_WAIT;
	endproperty
	a_abort: assert property (p_abort) else $error("request not honored");

endmodule

// ---- testbench/cfgsq_flash_model.sv ----
/*
 Internal flash responder for the configuration sequence controller.
 Assumes one read outstanding at a time; fail_now makes it answer with an error.
*/
`timescale 1ns/1ps
module cfgsq_flash_model (
	// Clock and reset.
	input wire logic clk,
	input wire logic nrst,
	// Read port.
	input wire cfgsq_pkg::cfgsq_flash_req_t flash_rd,
	input wire logic fail_now,
	output logic flash_valid,
	output logic flash_error,
	output logic [cfgsq_pkg::DATA_W-1:0] flash_data
);
	// ==========================================
	// Answers one cycle after a request; idle data toggles every cycle.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			flash_valid <= 1'b0;
			flash_error <= 1'b0;
			flash_data <= 32'h00000000;
		end else begin
			flash_valid <= flash_rd.req && !flash_valid && !fail_now;
			flash_error <= flash_rd.req && !flash_error && fail_now;
			flash_data <= (flash_rd.req && !flash_valid) ? {16'hC3A5, flash_rd.addr} : ~flash_data;
		end
	end
endmodule

// ---- testbench/tb_config_sequence_controller.sv ----
/*
 Testbench for the configuration sequence controller.
 Assumes open-drain lines with pull-ups and a flash model at the read port.
*/
`timescale 1ns/1ps
module tb_config_sequence_controller;
	logic clk = 0, nrst = 0, auto_restart = 0, io_config_bits = 0, keep_config_pins = 0;
	logic reconfig_request_n = 1, image_select = 1, scan_port_enable = 0, fail_now = 0;
	logic global_clear_n = 1, global_output_enable = 1, integrity_fault = 0;
	logic [2:0] supply_good = 3'b000;
	logic config_status_n_in, config_status_n_out, config_status_n_oe_n;
	logic config_complete_in, config_complete_out, config_complete_oe_n;
	logic integrity_fault_out, integrity_fault_oe_n, flash_valid, flash_error, flash_bank;
	logic [31:0] flash_data;
	logic io_weak_pullup, io_tristate, user_mode, user_clear_n, user_oe;
	logic pins_user_io, scan_pins_user_io;
	cfgsq_pkg::cfgsq_flash_req_t flash_rd;
	cfgsq_pkg::cfgsq_mem_wr_t mem_wr;
	cfgsq_pkg::cfgsq_state_t stage;
	int err_count = 0, samples_checked = 0, wcnt = 0;

	assign config_status_n_in = config_status_n_oe_n ? 1'b1 : config_status_n_out;
	assign config_complete_in = config_complete_oe_n ? 1'b1 : config_complete_out;

	cfgsq_controller #(.IMAGE_WORDS(4), .INIT_CYCLES(4)) cfgsq_controller_inst (.clk, .nrst,
		.supply_good, .auto_restart, .io_config_bits, .keep_config_pins, .reconfig_request_n,
		.config_status_n_in, .config_status_n_out, .config_status_n_oe_n, .config_complete_in,
		.config_complete_out, .config_complete_oe_n, .image_select, .scan_port_enable,
		.global_clear_n, .global_output_enable, .integrity_fault, .integrity_fault_out,
		.integrity_fault_oe_n, .flash_rd, .flash_valid, .flash_error, .flash_data, .flash_bank,
		.mem_wr, .io_weak_pullup, .io_tristate, .user_mode, .user_clear_n, .user_oe,
		.pins_user_io, .scan_pins_user_io, .stage);
	cfgsq_flash_model cfgsq_flash_model_inst (.clk, .nrst, .flash_rd, .fail_now,
		.flash_valid, .flash_error, .flash_data);

	initial begin
		forever #4 clk = ~clk;
	end

	// ==========================================
	// Checking and closing.
	task automatic chk(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic wait_st(input cfgsq_pkg::cfgsq_state_t s, input int n);
		int i;
		for (i = 0; i < n && stage !== s; i++) @(negedge clk);
		chk(stage === s, "stage not reached");
	endtask

	task automatic pulse_req();
		reconfig_request_n = 0;
		repeat (8) @(negedge clk);
		reconfig_request_n = 1;
	endtask

	// ==========================================
	// Image write monitor.
	always @(negedge clk) begin
		if (stage === cfgsq_pkg::ST_POR_WAIT) wcnt = 0;
		if (nrst && mem_wr.we === 1'b1) begin
			chk(mem_wr.addr === wcnt[15:0] && mem_wr.data === {16'hC3A5, wcnt[15:0]}, "word");
			wcnt++;
		end
	end

	initial begin
		#100000;
		err_count++;
		end_of_test();
	end

	// ==========================================
	// Test sequence.
	initial begin
		repeat (4) @(negedge clk);
		nrst = 1;
		supply_good = 3'b011;
		repeat (20) @(negedge clk);
		chk(stage === cfgsq_pkg::ST_POWERUP && config_status_n_in === 1'b0, "not held");
		supply_good = 3'b111;
		@(negedge clk);
		chk(stage === cfgsq_pkg::ST_POR_WAIT, "no delay");
		repeat (100) @(negedge clk);
		chk(stage === cfgsq_pkg::ST_POR_WAIT, "delay short");
		wait_st(cfgsq_pkg::ST_CONFIG, 40);
		chk(io_tristate === 1'b1 && io_weak_pullup === 1'b0 && user_mode === 1'b0, "io");
		chk(config_complete_in === 1'b0 && pins_user_io === 1'b0, "complete early");
		wait_st(cfgsq_pkg::ST_INIT, 80);
		chk(wcnt === 4 && config_complete_in === 1'b1, "copy");
		@(negedge clk);
		chk(stage === cfgsq_pkg::ST_INIT, "init short");
		wait_st(cfgsq_pkg::ST_USER, 10);
		chk(user_mode === 1'b1 && pins_user_io === 1'b1 && flash_bank === 1'b1, "user");
		chk(scan_pins_user_io === 1'b1, "scan pins user");
		integrity_fault = 1;
		global_clear_n = 0;
		global_output_enable = 0;
		@(negedge clk);
		chk(integrity_fault_oe_n === 1'b0 && user_clear_n === 1'b0 && user_oe === 1'b0, "pins");
		chk(integrity_fault_out === 1'b0, "fault level");
		io_config_bits = 1;
		reconfig_request_n = 0;
		@(negedge clk);
		chk(config_status_n_in === 1'b0 && config_complete_in === 1'b0, "lines");
		chk(io_weak_pullup === 1'b1 && user_mode === 1'b0, "pull-up");
		fail_now = 1;
		pulse_req();
		wait_st(cfgsq_pkg::ST_ERROR, 200);
		repeat (10) @(negedge clk);
		chk(stage === cfgsq_pkg::ST_ERROR && config_status_n_in === 1'b0, "error");
		fail_now = 0;
		keep_config_pins = 1;
		scan_port_enable = 1;
		pulse_req();
		wait_st(cfgsq_pkg::ST_USER, 400);
		chk(pins_user_io === 1'b0 && wcnt === 4, "keep role");
		chk(scan_pins_user_io === 1'b0, "scan keep role");
		auto_restart = 1;
		fail_now = 1;
		pulse_req();
		wait_st(cfgsq_pkg::ST_ERROR, 200);
		fail_now = 0;
		wait_st(cfgsq_pkg::ST_POR_WAIT, 5);
		wait_st(cfgsq_pkg::ST_USER, 400);
		end_of_test();
	end
endmodule
